/* rtl/cfb_top.v */
// cfb_top.v: one logic cluster with register port for its configuration
`timescale 1ns/1ps
`include "cfb_defs.vh"
module cfb_top (
  input  wire        CORE_CLK,
  input  wire        RST,
  input  wire [9:0]  REG_ADDR,
  input  wire [31:0] REG_WDATA,
  input  wire        REG_WR,
  input  wire        REG_RD,
  output wire [31:0] REG_RDATA,
  input  wire [35:0] CLUSTER_IN,
  input  wire [2:0]  GLOBAL_CLOCK_PIN,
  input  wire        GLOBAL_SET_RESET,
  input  wire [1:0]  GLOBAL_OE,
  output wire [17:0] MATRIX_OUT,
  output wire [17:0] PIN_OUT,
  output wire [17:0] PIN_OE
);
  // --------------------------------------------------------------
  // declarations
  // --------------------------------------------------------------
  reg  [31:0]  mc_cfg_q [0:`CFB_N_MC-1];
  reg  [1:0]   ctrl_q;
  reg  [31:0]  rdata_q;
  reg  [31:0]  rdata_d;
  reg  [17:0]  fb_q;
  reg  [17:0]  clk_lvl_q;
  wire [17:0]  clk_lvl;
  wire [17:0]  clk_pulse;
  wire [17:0]  mc_out;
  wire [17:0]  mc_state;
  wire [17:0]  mc_oe;
  wire [17:0]  fb;
  wire [107:0] lits;
  wire [89:0]  pt;
  wire [31:0]  term_rd;
  wire [18:0]  chain_a;
  wire [18:0]  chain_b;
  wire         run;
  wire         fb_on;
  wire         is_term;
  wire         is_mc;
  wire [4:0]   mc_idx;
  wire         term_wr;
  wire         mc_wr;
  integer      k;

  // --------------------------------------------------------------
  // address decode
  // --------------------------------------------------------------
  assign is_term = ~REG_ADDR[9] & (REG_ADDR[8:2] < `CFB_N_PT_W);
  assign is_mc   = (REG_ADDR >= `CFB_A_MC_BASE) &
                   (REG_ADDR < `CFB_A_MC_END);
  assign mc_idx  = REG_ADDR[4:0];
  assign run     = ctrl_q[`CFB_C_RUN];
  assign fb_on   = ctrl_q[`CFB_C_FB] & `CFB_HAS_FB;

  // configuration is frozen while the cluster runs
  assign term_wr = REG_WR & is_term & ~run;
  assign mc_wr   = REG_WR & is_mc & ~run;

  // --------------------------------------------------------------
  // configuration registers
  // --------------------------------------------------------------
  always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      for (k = 0; k < `CFB_N_MC; k = k + 1) begin
        mc_cfg_q[k] <= `CFB_MC_RST;
      end
    end else if (mc_wr) begin
      mc_cfg_q[mc_idx] <= REG_WDATA;
    end
  end

  // run and feedback enable stay writable at all times
  always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      ctrl_q <= `CFB_CTRL_RST;
    end else if (REG_WR && (REG_ADDR == `CFB_A_CTRL)) begin
      ctrl_q <= REG_WDATA[1:0];
    end
  end

  // --------------------------------------------------------------
  // read port
  // --------------------------------------------------------------
  always @* begin
    rdata_d = 32'h0;
    if (is_term) begin
      rdata_d = term_rd;
    end else if (is_mc) begin
      rdata_d = mc_cfg_q[mc_idx];
    end else begin
      case (REG_ADDR)
        `CFB_A_CTRL: begin
          rdata_d = {30'h0, ctrl_q};
        end
        `CFB_A_STATE: begin
          rdata_d = {14'h0, mc_state};
        end
        `CFB_A_OUT: begin
          rdata_d = {14'h0, mc_out};
        end
        `CFB_A_OE: begin
          rdata_d = {14'h0, mc_oe};
        end
        default: begin
          rdata_d = 32'h0;
        end
      endcase
    end
  end

  // data stands only in the cycle after the strobe
  always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      rdata_q <= 32'h0;
    end else if (REG_RD) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= 32'h0;
    end
  end

  assign REG_RDATA = rdata_q;

  // --------------------------------------------------------------
  // local feedback
  // --------------------------------------------------------------
  // feedback is taken one core cycle late: this breaks the loop that
  // a combinational cell would close through its own terms; cell
  // clocks are edge pulses at least two cycles apart, so registered
  // counters still see their fresh state
  always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      fb_q <= 18'h0;
    end else begin
      fb_q <= mc_out;
    end
  end

  assign fb = fb_on ? fb_q : 18'h0;

  // true and complement of every input and every feedback line
  assign lits = {~fb, fb, ~CLUSTER_IN, CLUSTER_IN};

  // --------------------------------------------------------------
  // AND-array
  // --------------------------------------------------------------
  cfb_and_array u_array (
    .clk      (CORE_CLK),
    .rst      (RST),
    .wr_en    (term_wr),
    .term_idx (REG_ADDR[8:2]),
    .word_idx (REG_ADDR[1:0]),
    .wdata    (REG_WDATA),
    .lits     (lits),
    .rd_word  (term_rd),
    .terms    (pt)
  );

  // --------------------------------------------------------------
  // clock edge detect
  // --------------------------------------------------------------
  // held at the level while stopped, so starting makes no false edge
  always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      clk_lvl_q <= 18'h0;
    end else begin
      clk_lvl_q <= clk_lvl;
    end
  end

  assign clk_pulse = clk_lvl & ~clk_lvl_q & {18{run}};

  // --------------------------------------------------------------
  // allocator chains
  // --------------------------------------------------------------
  // chain a carries donated sums upward, chain b downward; each is
  // acyclic, and a hop stands for one borrow delay step, which this
  // zero-delay model does not show
  assign chain_a[0]         = 1'b0;
  assign chain_b[`CFB_N_MC] = 1'b0;

  // --------------------------------------------------------------
  // macrocells
  // --------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < `CFB_N_MC; i = i + 1) begin : g_mc
      wire [31:0] c;
      wire [4:0]  dir;
      wire [4:0]  dat_en;
      wire        own;
      wire        in_a;
      wire        in_b;
      wire        don_a;
      wire        don_b;
      wire        sum;
      wire        d_in;
      wire [1:0]  csel;
      wire        global_clock_pin;
      wire        gsr_val;
      wire        set_in;
      wire        clr_in;
      wire [1:0]  oesel;
      wire        goe_inv;
      reg         oe;

      assign c      = mc_cfg_q[i];
      assign dir    = pt[i*`CFB_N_DIR +: `CFB_N_DIR];
      assign dat_en = c[`CFB_F_DAT +: `CFB_N_DIR];

      // direct terms go straight into the OR
      assign own   = |(dir & dat_en);
      assign in_a  = c[`CFB_F_TKA] & chain_a[i];
      assign in_b  = c[`CFB_F_TKB] & chain_b[i+1];
      assign don_a = c[`CFB_F_DNA];
      assign don_b = c[`CFB_F_DNB];

      // a donor passes its own sum on, plus what it took from the same chain
      assign chain_a[i+1] = don_a & (own | in_a);
      assign chain_b[i]   = don_b & (own | in_b);

      assign sum  = ((don_a | don_b) ? 1'b0 : own) | in_a | in_b;
      assign d_in = sum ^ c[`CFB_F_OINV];

      // clock source with polarity chosen per cell
      assign csel = c[`CFB_F_CSEL +: 2];
      assign global_clock_pin  = (csel == `CFB_CSEL_PT) ? dir[`CFB_PT_CLK]
                                           : GLOBAL_CLOCK_PIN[csel];
      assign clk_lvl[i] = global_clock_pin ^ c[`CFB_F_CINV];

      // global set/reset forces the chosen state in every cell unless the cell's term reset meets a global set, where clear wins
      assign gsr_val = c[`CFB_F_GSRV];
      assign set_in  = (c[`CFB_F_PSET] & dir[`CFB_PT_SET]) |
                       (GLOBAL_SET_RESET & gsr_val);
      assign clr_in  = (c[`CFB_F_PRST] & dir[`CFB_PT_RST]) |
                       (GLOBAL_SET_RESET & ~gsr_val);

      cfb_macrocell u_mc (
        .clk       (CORE_CLK),
        .rst       (RST),
        .run       (run),
        .mode      (c[`CFB_F_MODE +: 2]),
        .preload   (c[`CFB_F_PRE]),
        .clk_pulse (clk_pulse[i]),
        .d_in      (d_in),
        .set_in    (set_in),
        .clr_in    (clr_in),
        .state     (mc_state[i]),
        .mc_out    (mc_out[i])
      );

      // output enable from a term, a global enable, or always on
      assign oesel   = c[`CFB_F_OESEL +: 2];
      assign goe_inv = c[`CFB_F_GOEINV];
      always @* begin
        case (oesel)
          `CFB_OE_PT: begin
            oe = dir[`CFB_PT_OE];
          end
          `CFB_OE_G0: begin
            oe = GLOBAL_OE[0] ^ goe_inv;
          end
          `CFB_OE_G1: begin
            oe = GLOBAL_OE[1] ^ goe_inv;
          end
          default: begin
            oe = 1'b1;
          end
        endcase
      end
      assign mc_oe[i] = oe;

      // only bonded outputs reach a pin buffer
      if (i < `CFB_PIN_OUTS) begin : g_pin
        assign PIN_OUT[i] = mc_out[i];
        assign PIN_OE[i]  = oe;
      end else begin : g_nopin
        assign PIN_OUT[i] = 1'b0;
        assign PIN_OE[i]  = 1'b0;
      end
    end
  endgenerate

  // --------------------------------------------------------------
  // outputs to the matrix
  // --------------------------------------------------------------
  assign MATRIX_OUT = mc_out;
endmodule

/* inc/cfb_defs.vh */
// cfb_defs.vh: constants for the programmable logic cluster
`ifndef CFB_DEFS_VH
`define CFB_DEFS_VH
`define CFB_N_IN      36
`define CFB_N_MC      18
`define CFB_N_PT      90
`define CFB_N_PT_W    7'd90
`define CFB_N_LIT     108
`define CFB_N_DIR     5
`define CFB_PIN_OUTS  18
`define CFB_HAS_FB    1'b1
`define CFB_W3_MASK   32'h00000fff
`define CFB_A_MC_BASE 10'h200
`define CFB_A_MC_END  10'h212
`define CFB_A_CTRL    10'h220
`define CFB_A_STATE   10'h221
`define CFB_A_OUT     10'h222
`define CFB_A_OE      10'h223
`define CFB_MC_RST    32'h00000000
`define CFB_CTRL_RST  2'h0
`define CFB_C_RUN     0
`define CFB_C_FB      1
`define CFB_F_DAT     0
`define CFB_F_TKA     5
`define CFB_F_DNA     6
`define CFB_F_TKB     7
`define CFB_F_DNB     8
`define CFB_F_MODE    9
`define CFB_F_CSEL    11
`define CFB_F_CINV    13
`define CFB_F_OINV    14
`define CFB_F_PRE     15
`define CFB_F_GSRV    16
`define CFB_F_PSET    17
`define CFB_F_PRST    18
`define CFB_F_OESEL   19
`define CFB_F_GOEINV  21
`define CFB_MODE_COMB 2'h0
`define CFB_MODE_D    2'h1
`define CFB_MODE_T    2'h2
`define CFB_CSEL_PT   2'h3
`define CFB_OE_PT     2'h0
`define CFB_OE_G0     2'h1
`define CFB_OE_G1     2'h2
`define CFB_PT_CLK    0
`define CFB_PT_SET    1
`define CFB_PT_RST    2
`define CFB_PT_OE     3
`endif

/* rtl/cfb_and_array.v */
// cfb_and_array.v: literal mask memory and product term evaluation
`timescale 1ns/1ps
`include "cfb_defs.vh"
module cfb_and_array (
  input  wire         clk,
  input  wire         rst,
  input  wire         wr_en,
  input  wire [6:0]   term_idx,
  input  wire [1:0]   word_idx,
  input  wire [31:0]  wdata,
  input  wire [107:0] lits,
  output wire [31:0]  rd_word,
  output wire [89:0]  terms
);
  reg  [127:0] mask_q [0:`CFB_N_PT-1];
  wire [31:0]  raw_word;
  integer      k;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      for (k = 0; k < `CFB_N_PT; k = k + 1) begin
        mask_q[k] <= 128'h0;
      end
    end else if (wr_en) begin
      mask_q[term_idx][{word_idx, 5'h00} +: 32] <= wdata;
    end
  end

  assign raw_word = mask_q[term_idx][{word_idx, 5'h00} +: 32];
  // bits above the last literal read as zero
  assign rd_word  = (word_idx == 2'h3) ? (raw_word & `CFB_W3_MASK)
                                       : raw_word;

  // --------------------------------------------------------------
  // product terms
  // --------------------------------------------------------------
  // a term with no literal selected stays low, like an erased cell
  genvar g;
  generate
    for (g = 0; g < `CFB_N_PT; g = g + 1) begin : g_pt
      wire [107:0] m;
      assign m        = mask_q[g][107:0];
      assign terms[g] = (|m) & (&(~m | lits));
    end
  endgenerate
endmodule

/* rtl/cfb_macrocell.v */
// cfb_macrocell.v: storage element of one macrocell
`timescale 1ns/1ps
`include "cfb_defs.vh"
module cfb_macrocell (
  input  wire       clk,
  input  wire       rst,
  input  wire       run,
  input  wire [1:0] mode,
  input  wire       preload,
  input  wire       clk_pulse,
  input  wire       d_in,
  input  wire       set_in,
  input  wire       clr_in,
  output wire       state,
  output wire       mc_out
);
  reg  state_q;
  reg  state_d;
  wire held;

  // set and clear show at once at state, and at mc_out in every mode but comb, clear dominant
  assign held = clr_in ? 1'b0 : (set_in ? 1'b1 : state_q);

  always @* begin
    state_d = state_q;
    if (!run) begin
      state_d = preload;
    end else if (clr_in) begin
      state_d = 1'b0;
    end else if (set_in) begin
      state_d = 1'b1;
    end else if (clk_pulse) begin
      case (mode)
        `CFB_MODE_D: begin
          state_d = d_in;
        end
        `CFB_MODE_T: begin
          state_d = state_q ^ d_in;
        end
        default: begin
          state_d = state_q;
        end
      endcase
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= 1'b0;
    end else begin
      state_q <= state_d;
    end
  end

  assign state  = held;
  // bypass: the sum goes straight out
  assign mc_out = (mode == `CFB_MODE_COMB) ? d_in : held;
endmodule

/* verification/cfb_top_chk.sv */
// cfb_top_chk.sv: port assertions for the logic cluster
`timescale 1ns/1ps
module cfb_top_chk (
  input wire logic        CORE_CLK,
  input wire logic        RST,
  input wire logic [9:0]  REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic        REG_WR,
  input wire logic        REG_RD,
  input wire logic [31:0] REG_RDATA,
  input wire logic [35:0] CLUSTER_IN,
  input wire logic [2:0]  GLOBAL_CLOCK_PIN,
  input wire logic        GLOBAL_SET_RESET,
  input wire logic [1:0]  GLOBAL_OE,
  input wire logic [17:0] MATRIX_OUT,
  input wire logic [17:0] PIN_OUT,
  input wire logic [17:0] PIN_OE
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  // ----
  // register port
  // ----
  a_rdata_idle: assert property (
    !$past(REG_RD) |-> REG_RDATA == 32'h0) else $error("stray read data");
  a_unmapped_zero: assert property (
    REG_RD && REG_ADDR >= 10'h224 |=> REG_RDATA == 32'h0)
    else $error("unmapped read not zero");
  a_word3_mask: assert property (
    REG_RD && REG_ADDR < 10'h168 && REG_ADDR[1:0] == 2'h3
    |=> REG_RDATA[31:12] == 20'h0) else $error("term word3 too wide");
  a_ctrl_width: assert property (
    REG_RD && REG_ADDR == 10'h220 |=> REG_RDATA[31:2] == 30'h0)
    else $error("control read too wide");
  a_state_width: assert property (
    REG_RD && REG_ADDR == 10'h221 |=> REG_RDATA[31:18] == 14'h0)
    else $error("more than 18 cell states");
  a_out_read: assert property (
    REG_RD && REG_ADDR == 10'h222 |=> REG_RDATA[17:0] == $past(MATRIX_OUT))
    else $error("output read mismatch");
  a_oe_read: assert property (
    REG_RD && REG_ADDR == 10'h223 |=> REG_RDATA[17:0] == $past(PIN_OE))
    else $error("enable read mismatch");
  // ----
  // pins
  // ----
  // every cell is bonded here, so pins mirror the matrix side
  a_pin_mirror: assert property (
    PIN_OUT == MATRIX_OUT) else $error("pin output differs");
  cover property (GLOBAL_SET_RESET);
  cover property (REG_RD && REG_ADDR == 10'h222);
  cover property ($rose(GLOBAL_CLOCK_PIN[1]));
endmodule

bind cfb_top cfb_top_chk chk_u (
  .CORE_CLK(CORE_CLK), .RST(RST), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
  .REG_RDATA(REG_RDATA), .CLUSTER_IN(CLUSTER_IN),
  .GLOBAL_CLOCK_PIN(GLOBAL_CLOCK_PIN), .GLOBAL_SET_RESET(GLOBAL_SET_RESET),
  .GLOBAL_OE(GLOBAL_OE), .MATRIX_OUT(MATRIX_OUT), .PIN_OUT(PIN_OUT),
  .PIN_OE(PIN_OE));

/* verification/cfb_far_end.sv */
// cfb_far_end.sv: routing matrix and pin buffer stand-in
`timescale 1ns/1ps
module cfb_far_end (
  input  wire logic [35:0] drive,
  input  wire logic [17:0] pin_out,
  input  wire logic [17:0] pin_oe,
  output wire logic [35:0] cluster_in,
  output wire logic [17:0] pin_lvl
);
  // straight routes only; wired-and merging is not modelled
  assign cluster_in = drive;
  // a released pin floats to its pull-up level
  assign pin_lvl = pin_out | ~pin_oe;
endmodule

/* verification/tb_cpld_function_block.sv */
// tb_cpld_function_block.sv: directed tests of one logic cluster
`timescale 1ns/1ps
`define CHK(nm, e, a) begin n_compared++; if ((a) !== (e)) begin \
  err_count++; $display("wrong value %s exp %h got %h", nm, e, a); end end
module tb_cpld_function_block;
  logic        core_clk  = 1'b0;
  logic        rst       = 1'b1;
  logic [9:0]  reg_addr  = 10'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic [35:0] drive     = 36'h0;
  logic [2:0]  global_clock_pin       = 3'h0;
  logic        global_set_reset       = 1'b0;
  logic [1:0]  goe       = 2'h0;
  wire  [31:0] reg_rdata;
  wire  [35:0] cluster_in;
  wire  [17:0] mat_out, pin_out, pin_oe, pin_lvl;
  int          err_count  = 0;
  int          n_compared = 0;
  int          cyc        = 0;
  // terms first, then cells; cell writes are refused once running
  // cell 6 reads cell 5 back through feedback; cells 9 to 11 chain upward
  logic [9:0]  cfg_a [24] = '{10'h000, 10'h015, 10'h028, 10'h02c, 10'h030,
    10'h03c, 10'h050, 10'h07a, 10'h0a0, 10'h0b4, 10'h167, 10'h200, 10'h201,
    10'h202, 10'h203, 10'h204, 10'h205, 10'h206, 10'h207, 10'h208, 10'h209,
    10'h20a, 10'h20b, 10'h211};
  logic [31:0] cfg_d [24] = '{32'h1, 32'h10, 32'h1, 32'h4, 32'h8, 32'h1,
    32'h2, 32'h2000, 32'h20, 32'h40, 32'hffffffff, 32'h80001, 32'h300001,
    32'h70201, 32'h2a01, 32'h1401, 32'h8200, 32'h1, 32'h80, 32'h101,
    32'h41, 32'h60, 32'h20, 32'h180000};

  always #12.5 core_clk = ~core_clk;

  cfb_far_end far_u (.drive(drive), .pin_out(pin_out), .pin_oe(pin_oe),
    .cluster_in(cluster_in), .pin_lvl(pin_lvl));
  cfb_top dut_u (.CORE_CLK(core_clk), .RST(rst), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_RDATA(reg_rdata), .CLUSTER_IN(cluster_in), .GLOBAL_CLOCK_PIN(global_clock_pin),
    .GLOBAL_SET_RESET(global_set_reset), .GLOBAL_OE(goe), .MATRIX_OUT(mat_out),
    .PIN_OUT(pin_out), .PIN_OE(pin_oe));
  // ----
  // tasks
  // ----
  task automatic wr(input logic [9:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask
  task automatic ck(input string nm, input logic [9:0] a,
                    input logic [31:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1;
    `CHK(nm, e, reg_rdata)
  endtask
  // holds every level three cycles, above the one-cycle minimum
  task automatic st(input logic [35:0] v, input logic [2:0] g,
                    input logic s);
    @(posedge core_clk);
    drive <= v;
    global_clock_pin   <= g;
    global_set_reset   <= s;
    repeat (3) @(posedge core_clk);
    #1;
  endtask
  task automatic o(input string nm, input int i, input logic e);
    `CHK(nm, e, mat_out[i])
  endtask
  task complete_run;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      complete_run();
    end
  end
  // ----
  // tests
  // ----
  initial begin
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    ck("ctrl", 10'h220, 32'h0);
    ck("state", 10'h221, 32'h0);
    ck("cell cfg", 10'h202, 32'h0);
    ck("unmapped", 10'h3ff, 32'h0);
    for (int k = 0; k < 24; k++) wr(cfg_a[k], cfg_d[k]);
    ck("word3", 10'h167, 32'h00000fff);
    ck("cell cfg", 10'h202, 32'h00070201);
    st(36'h0, 3'h0, 1'b0);
    o("preload", 5, 1'b1);
    ck("state", 10'h221, 32'h20);
    $display("done: reset and preload");
    wr(10'h220, 32'h3);
    st(36'h0, 3'h0, 1'b0);
    o("true lit", 0, 1'b0);
    o("inv lit", 1, 1'b1);
    st(36'h1, 3'h0, 1'b0);
    o("true lit", 0, 1'b1);
    o("inv lit", 1, 1'b0);
    o("feedback", 6, 1'b1);
    o("borrow", 7, 1'b0);
    o("chain", 11, 1'b0);
    st(36'h21, 3'h0, 1'b0);
    o("borrow", 7, 1'b1);
    st(36'h40, 3'h0, 1'b0);
    o("chain", 11, 1'b1);
    o("donor", 9, 1'b0);
    $display("done: and-array");
    st(36'h1, 3'h1, 1'b0);
    o("d load", 2, 1'b1);
    o("feedback", 6, 1'b0);
    st(36'h0, 3'h0, 1'b0);
    o("d hold", 2, 1'b1);
    st(36'h0, 3'h1, 1'b0);
    o("d load", 2, 1'b0);
    st(36'h1, 3'h2, 1'b0);
    o("inv clk", 3, 1'b0);
    st(36'h1, 3'h0, 1'b0);
    o("inv clk", 3, 1'b1);
    for (int k = 0; k < 3; k++) begin
      st(36'h2, 3'h4, 1'b0);
      o("toggle", 4, ~k[0]);
      st(36'h2, 3'h0, 1'b0);
    end
    $display("done: registers");
    st(36'h4, 3'h0, 1'b0);
    o("set", 2, 1'b1);
    st(36'hc, 3'h0, 1'b0);
    o("clear", 2, 1'b0);
    st(36'h0, 3'h0, 1'b1);
    o("gsr set", 2, 1'b1);
    o("gsr clear", 4, 1'b0);
    st(36'h0, 3'h0, 1'b0);
    ck("out reg", 10'h222, 32'h6);
    $display("done: set and reset");
    @(posedge core_clk) goe <= 2'h1;
    st(36'h0, 3'h0, 1'b0);
    `CHK("pin oe", 18'h20003, pin_oe)
    ck("oe reg", 10'h223, 32'h20003);
    @(posedge core_clk) goe <= 2'h2;
    st(36'h0, 3'h0, 1'b0);
    `CHK("pin oe", 18'h20000, pin_oe)
    `CHK("pin lvl", 18'h1ffff, pin_lvl)
    wr(10'h200, 32'h0);
    ck("locked cfg", 10'h200, 32'h80001);
    $display("done: enables and lock");
    complete_run();
  end
endmodule
